// *** bench/parallel_port_with_pin_interrupts_test.sv ***
// self-checking bench of the parallel port with pin interrupts
`timescale 1ns/1ns
`default_nettype none
module parallel_port_with_pin_interrupts_test;
  import gpio_port_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [7:0]  pa_in, pa_out, pa_oe_n, pa_ibuf_en, pa_pull_up, pa_pull_down, pa_slew, pa_drive;
  logic [7:0]  pa_dig_en = 8'h00, pa_dig_out = 8'h00, pa_dig_oe = 8'h00, pa_ana_en = 8'h00;
  logic [7:0]  a_ext_en = 8'h00, a_ext_val = 8'h00;
  logic [5:0]  pg_in, pg_out, pg_oe_n, pg_ibuf_en, pg_pull_up, pg_slew, pg_drive;
  logic [5:0]  pg_dig_en = 6'h00, pg_dig_out = 6'h00, pg_dig_oe = 6'h00, pg_ana_en = 6'h00;
  logic [5:0]  pg_out_only = 6'h00;
  int          mismatches = 0, checked = 0, cycles = 0;
  gpio_port dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pa_in, .pa_out, .pa_oe_n, .pa_ibuf_en, .pa_pull_up, .pa_pull_down, .pa_slew,
    .pa_drive, .pa_dig_en, .pa_dig_out, .pa_dig_oe, .pa_ana_en, .pg_in, .pg_out, .pg_oe_n,
    .pg_ibuf_en, .pg_pull_up, .pg_slew, .pg_drive, .pg_dig_en, .pg_dig_out, .pg_dig_oe,
    .pg_ana_en, .pg_out_only, .irq);
  pin_board #(.n(8)) board_a (.clk({8{aclk}}), .out(pa_out), .oe_n(pa_oe_n), .pull_up(pa_pull_up),
    .pull_down(pa_pull_down), .ext_en(a_ext_en), .ext_val(a_ext_val), .level(pa_in));
  pin_board #(.n(6)) board_g (.clk({6{aclk}}), .out(pg_out), .oe_n(pg_oe_n), .pull_up(pg_pull_up),
    .pull_down(6'h00), .ext_en(6'h00), .ext_val(6'h00), .level(pg_in));
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      final_report();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rdr(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task settle;
    repeat (4) @(posedge aclk);
  endtask
  task t_reset;
    chk(pa_oe_n, 8'hff);
    chk({pa_pull_up, pa_pull_down, pa_drive}, 24'h0);
    chk({pa_slew, pg_slew}, 14'h3fff);
    chk(pa_ibuf_en, 8'hff);
    chk({pg_drive, pg_pull_up, pg_oe_n}, 18'h0003f);
    rdr(off_porta_dir);
    chk(rd, 32'h0);
    wr(off_portg_slew_en, 32'h3f);
    $display("test reset done");
  endtask
  task t_dir;
    a_ext_en  <= 8'hff;
    a_ext_val <= 8'hbc;
    wr(off_porta_data, 32'ha5);
    wr(off_porta_dir, 32'h0f);
    settle();
    chk(pa_oe_n, 8'hf0);
    rdr(off_porta_data);
    chk(rd, 32'hb5);
    pa_ana_en <= 8'h81;
    settle();
    chk({pa_ibuf_en, pa_oe_n}, 16'h7ef1);
    rdr(off_porta_data);
    chk(rd, 32'h35);
    pa_ana_en  <= 8'h00;
    pa_dig_en  <= 8'h10;
    pa_dig_oe  <= 8'h10;
    pa_dig_out <= 8'h10;
    settle();
    chk({pa_oe_n[4], pa_out[4]}, 2'b01);
    rdr(off_porta_data);
    chk(rd, 32'hb5);
    pa_dig_en  <= 8'h00;
    pa_dig_oe  <= 8'h00;
    pa_dig_out <= 8'h00;
    $display("test direction done");
  endtask
  task t_irq;
    a_ext_en  <= 8'h00;
    wr(off_porta_dir, 32'h0);
    wr(off_porta_pull_en, 32'h02);
    wr(off_porta_irq_pin_sel, 32'h02);
    settle();
    chk({pa_pull_up, pa_pull_down}, 16'h0200);
    wr(off_porta_irq_edge_sel, 32'h06);
    settle();
    chk({pa_pull_up, pa_pull_down}, 16'h0002);
    a_ext_en  <= 8'h06;
    a_ext_val <= 8'h00;
    wr(off_irq_mask, 32'h1);
    rdr(off_irq_status);
    a_ext_val <= 8'h04;
    settle();
    chk(irq, 1'b0);
    a_ext_val <= 8'h06;
    settle();
    a_ext_val <= 8'h04;
    settle();
    chk(irq, 1'b1);
    rdr(off_irq_status);
    chk(rd, 32'h1);
    settle();
    chk(irq, 1'b0);
    rdr(off_irq_status);
    chk(rd, 32'h0);
    $display("test interrupt done");
  endtask
  task t_portg;
    wr(off_portg_pull_en, 32'h3f);
    wr(off_portg_dir, 32'h01);
    wr(off_portg_slew_en, 32'h0);
    wr(off_portg_data, 32'h1);
    pg_out_only <= 6'h20;
    settle();
    chk(pg_pull_up, 6'h3e);
    chk(pg_slew, 6'h3e);
    chk(pg_ibuf_en, 6'h1f);
    chk(pg_oe_n, 6'h3e);
    chk(pg_out, 6'h01);
    rdr(off_portg_data);
    chk(rd, 32'h1f);
    pg_out_only <= 6'h00;
    rdr(8'h3c);
    chk(resp, axi_slverr);
    chk(rd, 32'h0);
    wr(off_irq_status, 32'h1);
    chk(resp, axi_slverr);
    $display("test port g done");
  endtask
  task t_rereset;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({pg_oe_n, pg_pull_up, pg_slew}, 18'h3f03f);
    rdr(off_portg_slew_en);
    chk(rd, 32'h3f);
    $display("test second reset done");
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_dir();
    t_irq();
    t_portg();
    t_rereset();
    final_report();
  end
endmodule
`default_nettype wire

// *** bench/pin_board.sv ***
// board side of the port pins: outside driver, pulls and floating lines
`timescale 1ns/1ns
`default_nettype none
module pin_board #(parameter int n = 8) (
  input  wire logic [n-1:0] clk,
  input  wire logic [n-1:0] out,
  input  wire logic [n-1:0] oe_n,
  input  wire logic [n-1:0] pull_up,
  input  wire logic [n-1:0] pull_down,
  input  wire logic [n-1:0] ext_en,
  input  wire logic [n-1:0] ext_val,
  output logic      [n-1:0] level
);
  logic [n-1:0] last_ff = '0;
  always_ff @(posedge clk[0]) last_ff <= level;
  always_comb begin
    for (int i = 0; i < n; i++) begin
      if (!oe_n[i]) level[i] = out[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else if (pull_up[i]) level[i] = 1'b1;
      else if (pull_down[i]) level[i] = 1'b0;
      // undriven line wanders
      else level[i] = ~last_ff[i];
    end
  end
endmodule
`default_nettype wire

// *** pkg/gpio_port_pkg.sv ***
// constants and register map of the parallel port with pin interrupts
// Contract
// - direction bit enables output buffer and picks latch or pin for data reads
// - input buffer stays on unless pin is analog or output-only
// - digital alternate function drives output buffer; direction still picks read source
// - analog function disables both digital buffers of the pin
// - input-direction bit with input buffer off reads as zero
// - port A pin-select bit one makes pin an interrupt source
// - port A edge bit zero pull-up falling/low; one pull-down rising/high
// - port G pull-enable turns on pull-up; no effect on output pins
// - pull-down only when interrupt active with rising polarity, else pull-up
// - port G slew-enable turns on slew limiting; no effect on input pins
// - reset gives inputs, functions off, slew on, low drive, pulls off
// - enabled shared peripheral overrides output value, output enable and pulls; slew, drive, read source and port A interrupts stay with the port
package gpio_port_pkg;
  localparam logic [7:0] off_porta_data       = 8'h00;
  localparam logic [7:0] off_porta_dir        = 8'h04;
  localparam logic [7:0] off_porta_irq_pin_sel  = 8'h08;
  localparam logic [7:0] off_porta_irq_edge_sel = 8'h0c;
  localparam logic [7:0] off_portg_data       = 8'h10;
  localparam logic [7:0] off_portg_dir        = 8'h14;
  localparam logic [7:0] off_portg_pull_en    = 8'h18;
  localparam logic [7:0] off_portg_slew_en    = 8'h1c;
  localparam logic [7:0] off_porta_drive      = 8'h20;
  localparam logic [7:0] off_portg_drive      = 8'h24;
  localparam logic [7:0] off_irq_status       = 8'h28;
  localparam logic [7:0] off_irq_mask         = 8'h2c;
  localparam logic [7:0] off_porta_pull_en    = 8'h30;
  localparam logic [7:0] off_porta_slew_en    = 8'h34;
  localparam int         porta_width          = 8;
  localparam int         portg_width          = 6;
  localparam logic [7:0] rst_dir              = 8'h00;
  localparam logic [7:0] rst_slew             = 8'hff;
  localparam logic [7:0] rst_drive            = 8'h00;
  localparam logic [7:0] rst_pull             = 8'h00;
  localparam logic [1:0] axi_okay             = 2'b00;
  localparam logic [1:0] axi_slverr           = 2'b10;
  localparam int         status_porta_bit     = 0;
endpackage

// *** src/gpio_port.sv ***
// parallel port a (8 pins, pin interrupts) and port g (6 pins) behind axi4-lite
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int na = porta_width,
  parameter int ng = portg_width
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic [na-1:0] pa_in,
  output logic [na-1:0]      pa_out,
  output logic [na-1:0]      pa_oe_n,
  output logic [na-1:0]      pa_ibuf_en,
  output logic [na-1:0]      pa_pull_up,
  output logic [na-1:0]      pa_pull_down,
  output logic [na-1:0]      pa_slew,
  output logic [na-1:0]      pa_drive,
  input  wire logic [na-1:0] pa_dig_en,
  input  wire logic [na-1:0] pa_dig_out,
  input  wire logic [na-1:0] pa_dig_oe,
  input  wire logic [na-1:0] pa_ana_en,
  input  wire logic [ng-1:0] pg_in,
  output logic [ng-1:0]      pg_out,
  output logic [ng-1:0]      pg_oe_n,
  output logic [ng-1:0]      pg_ibuf_en,
  output logic [ng-1:0]      pg_pull_up,
  output logic [ng-1:0]      pg_slew,
  output logic [ng-1:0]      pg_drive,
  input  wire logic [ng-1:0] pg_dig_en,
  input  wire logic [ng-1:0] pg_dig_out,
  input  wire logic [ng-1:0] pg_dig_oe,
  input  wire logic [ng-1:0] pg_ana_en,
  input  wire logic [ng-1:0] pg_out_only,
  output logic               irq
);
  logic [na-1:0] a_data_ff, a_dir_ff, a_ps_ff, a_es_ff, a_pe_ff, a_se_ff, a_ds_ff;
  logic [ng-1:0] g_data_ff, g_dir_ff, g_pe_ff, g_se_ff, g_ds_ff;
  logic [na-1:0] a_prev_ff;
  logic          stat_ff, mask_ff;
  logic [7:0]    awaddr_ff, araddr_ff;
  logic [31:0]   wdata_ff;
  logic          aw_ff, w_ff;
  logic [na-1:0] a_ibuf, a_rd, a_act, a_hit;
  logic [ng-1:0] g_ibuf, g_rd;
  logic          do_wr, rd_stat;
  logic [31:0]   nxt_rdata;
  logic          nxt_rerr;

  // buffers and pulls, ports a and g
  always_comb begin
    a_ibuf = ~pa_ana_en;
    a_rd = (a_dir_ff & a_data_ff) | (~a_dir_ff & a_ibuf & pa_in);
    a_act = a_es_ff ~^ pa_in;
    a_hit = a_ps_ff & a_act & ~a_prev_ff;
    g_ibuf = ~pg_ana_en & ~pg_out_only;
    g_rd = (g_dir_ff & g_data_ff) | (~g_dir_ff & g_ibuf & pg_in);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_out <= '0;
      pa_oe_n <= '1;
      pa_ibuf_en <= '1;
      pa_pull_up <= '0;
      pa_pull_down <= '0;
      pa_slew <= '1;
      pa_drive <= '0;
      pg_out <= '0;
      pg_oe_n <= '1;
      pg_ibuf_en <= '1;
      pg_pull_up <= '0;
      pg_slew <= '1;
      pg_drive <= '0;
    end else begin
      for (int i = 0; i < na; i++) begin
        pa_out[i] <= pa_dig_en[i] ? pa_dig_out[i] : a_data_ff[i];
        pa_oe_n[i] <= pa_ana_en[i] ? 1'b1 :
                      (pa_dig_en[i] ? ~pa_dig_oe[i] : ~a_dir_ff[i]);
        pa_ibuf_en[i] <= a_ibuf[i];
        pa_pull_down[i] <= a_pe_ff[i] & ~a_dir_ff[i] & ~pa_dig_en[i] & ~pa_ana_en[i]
                           & a_ps_ff[i] & a_es_ff[i];
        pa_pull_up[i] <= a_pe_ff[i] & ~a_dir_ff[i] & ~pa_dig_en[i] & ~pa_ana_en[i]
                         & ~(a_ps_ff[i] & a_es_ff[i]);
        pa_slew[i] <= a_se_ff[i];
        pa_drive[i] <= a_ds_ff[i];
      end
      for (int i = 0; i < ng; i++) begin
        pg_out[i] <= pg_dig_en[i] ? pg_dig_out[i] : g_data_ff[i];
        pg_oe_n[i] <= pg_ana_en[i] ? 1'b1 :
                      (pg_dig_en[i] ? ~pg_dig_oe[i] : ~g_dir_ff[i]);
        pg_ibuf_en[i] <= g_ibuf[i];
        pg_pull_up[i] <= g_pe_ff[i] & ~g_dir_ff[i] & ~pg_dig_en[i] & ~pg_ana_en[i];
        pg_slew[i] <= g_se_ff[i] | ~g_dir_ff[i];
        pg_drive[i] <= g_ds_ff[i];
      end
    end
  end

  // axi write channel capture
  assign do_wr = aw_ff & w_ff & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= axi_okay;
    end else begin
      s_axi_awready <= ~aw_ff & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_ff & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                   {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      if (do_wr) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_ff > off_porta_slew_en || awaddr_ff[1:0] != 2'b00 ||
                        awaddr_ff == off_irq_status) ? axi_slverr : axi_okay;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_data_ff <= '0;
      a_dir_ff <= rst_dir[na-1:0];
      a_ps_ff <= '0;
      a_es_ff <= '0;
      a_pe_ff <= rst_pull[na-1:0];
      a_se_ff <= rst_slew[na-1:0];
      a_ds_ff <= rst_drive[na-1:0];
      g_data_ff <= '0;
      g_dir_ff <= rst_dir[ng-1:0];
      g_pe_ff <= rst_pull[ng-1:0];
      g_se_ff <= rst_slew[ng-1:0];
      g_ds_ff <= rst_drive[ng-1:0];
      mask_ff <= 1'b0;
    end else if (do_wr) begin
      unique case (awaddr_ff)
        off_porta_data:         a_data_ff <= wdata_ff[na-1:0];
        off_porta_dir:          a_dir_ff <= wdata_ff[na-1:0];
        off_porta_irq_pin_sel:  a_ps_ff <= wdata_ff[na-1:0];
        off_porta_irq_edge_sel: a_es_ff <= wdata_ff[na-1:0];
        off_portg_data:         g_data_ff <= wdata_ff[ng-1:0];
        off_portg_dir:          g_dir_ff <= wdata_ff[ng-1:0];
        off_portg_pull_en:      g_pe_ff <= wdata_ff[ng-1:0];
        off_portg_slew_en:      g_se_ff <= wdata_ff[ng-1:0];
        off_porta_drive:        a_ds_ff <= wdata_ff[na-1:0];
        off_portg_drive:        g_ds_ff <= wdata_ff[ng-1:0];
        off_irq_mask:           mask_ff <= wdata_ff[status_porta_bit];
        off_porta_pull_en:      a_pe_ff <= wdata_ff[na-1:0];
        off_porta_slew_en:      a_se_ff <= wdata_ff[na-1:0];
        default:                ;
      endcase
    end
  end

  // edge history and latched port interrupt flag
  assign rd_stat = s_axi_arvalid & s_axi_arready & (s_axi_araddr == off_irq_status);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // starts active so a pin already at its active level raises no edge
      a_prev_ff <= '1;
      stat_ff <= 1'b0;
      irq <= 1'b0;
    end else begin
      a_prev_ff <= a_act;
      // a new detection outranks a clearing read in the same cycle
      if (|a_hit) stat_ff <= 1'b1;
      else if (rd_stat) stat_ff <= 1'b0;
      irq <= (stat_ff | (|a_hit)) & mask_ff & ~(rd_stat & ~(|a_hit));
    end
  end

  // read channel
  always_comb begin
    nxt_rdata = '0;
    nxt_rerr = 1'b0;
    unique case (s_axi_araddr)
      off_porta_data:         nxt_rdata[na-1:0] = a_rd;
      off_porta_dir:          nxt_rdata[na-1:0] = a_dir_ff;
      off_porta_irq_pin_sel:  nxt_rdata[na-1:0] = a_ps_ff;
      off_porta_irq_edge_sel: nxt_rdata[na-1:0] = a_es_ff;
      off_portg_data:         nxt_rdata[ng-1:0] = g_rd;
      off_portg_dir:          nxt_rdata[ng-1:0] = g_dir_ff;
      off_portg_pull_en:      nxt_rdata[ng-1:0] = g_pe_ff;
      off_portg_slew_en:      nxt_rdata[ng-1:0] = g_se_ff;
      off_porta_drive:        nxt_rdata[na-1:0] = a_ds_ff;
      off_portg_drive:        nxt_rdata[ng-1:0] = g_ds_ff;
      off_irq_status:         nxt_rdata[status_porta_bit] = stat_ff;
      off_irq_mask:           nxt_rdata[status_porta_bit] = mask_ff;
      off_porta_pull_en:      nxt_rdata[na-1:0] = a_pe_ff;
      off_porta_slew_en:      nxt_rdata[na-1:0] = a_se_ff;
      default:                nxt_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= axi_okay;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & ~s_axi_arvalid ? 1'b1 :
                       (~s_axi_arready & ~s_axi_rvalid);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= nxt_rdata;
        s_axi_rresp <= nxt_rerr ? axi_slverr : axi_okay;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // pin-side buffer, pull, slew, read and detection rules
  chk_analog_kills_oe: assert property (@(posedge aclk) disable iff (!aresetn)
    pa_ana_en[0] |=> pa_oe_n[0]) else $error("analog pin drove output");
  chk_dir_drives_oe: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pa_ana_en[0] && !pa_dig_en[0] && a_dir_ff[0]) |=> !pa_oe_n[0])
    else $error("output pin not driven");
  chk_dig_owns_out: assert property (@(posedge aclk) disable iff (!aresetn)
    pa_dig_en != '0 |=> ((pa_out ^ $past(pa_dig_out)) & $past(pa_dig_en)) == '0)
    else $error("peripheral lost output");
  chk_pull_exclusive: assert property (@(posedge aclk) disable iff (!aresetn)
    (pa_pull_up & pa_pull_down) == '0) else $error("both pulls on");
  chk_pg_pull_out: assert property (@(posedge aclk) disable iff (!aresetn)
    g_dir_ff != '0 |=> (pg_pull_up & $past(g_dir_ff)) == '0)
    else $error("pull on output pin");
  chk_flag_sticks: assert property (@(posedge aclk) disable iff (!aresetn)
    (|a_hit) |=> stat_ff) else $error("detection lost");
  chk_no_sel_no_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    (a_ps_ff == '0) |-> !(|a_hit)) else $error("unselected pin hit");
  chk_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    pa_ana_en != '0 |-> (a_rd & ~a_dir_ff & pa_ana_en) == '0)
    else $error("disabled input read");
  chk_pa_ibuf_off: assert property (@(posedge aclk) disable iff (!aresetn)
    pa_ana_en != '0 |=> (pa_ibuf_en & $past(pa_ana_en)) == '0)
    else $error("input buffer on for analog pin");
  chk_pg_ibuf_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (pg_ana_en | pg_out_only) != '0 |=> (pg_ibuf_en & $past(pg_ana_en | pg_out_only)) == '0)
    else $error("port g input buffer left on");
  chk_pg_slew_in: assert property (@(posedge aclk) disable iff (!aresetn)
    g_dir_ff != '1 |=> (~pg_slew & ~$past(g_dir_ff)) == '0)
    else $error("input pin lost slew setting");
  chk_pull_down_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    a_pe_ff != '0 |=> (pa_pull_down & ~$past(a_ps_ff & a_es_ff)) == '0)
    else $error("pull-down without rising interrupt");

  // interrupt flag walk: detect, raise, read back clear
  sequence s_edge_seen;
    (|a_hit) && mask_ff;
  endsequence
  sequence s_irq_raised;
    stat_ff && irq;
  endsequence
  sequence s_stat_read;
    rd_stat && !(|a_hit);
  endsequence
  sequence s_quiet;
    !stat_ff && !irq;
  endsequence
  chk_irq_raise: assert property (@(posedge aclk) disable iff (!aresetn)
    s_edge_seen |=> s_irq_raised) else $error("edge did not raise interrupt");
  chk_flag_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    s_stat_read |=> s_quiet) else $error("status read left flag set");
  chk_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    (stat_ff && mask_ff && !rd_stat) |=> irq) else $error("pending flag not signalled");
  chk_irq_masked: assert property (@(posedge aclk) disable iff (!aresetn)
    !mask_ff |=> !irq) else $error("interrupt while masked");
endmodule
`default_nettype wire
